// ---- sim/dfab_bank_bench.sv ----
// Self-checking bench for the drive flags and analog input bank
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    testsRun++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end
module dfab_bank_bench;
    import dfab_pkg::*;
    logic              ref_clk = 1'b0;
    logic              rst_n = 1'b0;
    dfab_req_t         busReq = '0;
    logic [31:0]       busRdata;
    logic              powerSwitchedOn = 1'b0;
    logic [15:0]       loopDuty = 16'h2345;
    logic              controlRestart = 1'b0;
    logic              firmwareDefaultInvert = 1'b1;
    logic              autoSetupStart = 1'b0;
    logic              motorIsStepper = 1'b1;
    dfab_adc_t         adcIn = '0;
    logic [15:0]       pwmDuty;
    logic              holdTorqueEn, fieldInverted, autoSetupNeeded, autoSetupDone;
    dfab_gains_t       gainSet;
    logic              inputOneCurrentSelect, inputTwoCurrentSelect;
    int                errors = 0;
    int                testsRun = 0;
    // Reset gain presets, entry 1 first
    logic [31:0]       presetTab [10] = '{32'h0000_0800, 32'h0, 32'h2ee0, 32'h1e,
        32'h668a0, 32'h2ee0, 32'h668a0, 32'h2ee0, 32'h3a980, 32'hafc8};
    localparam logic [23:0] LEGACY = {OBJ_DRIVE_FLAGS, SUB_LEGACY};
    localparam logic [23:0] FIELD = {OBJ_DRIVE_FLAGS, SUB_FIELD};
    localparam logic [23:0] KEEP = {OBJ_DRIVE_FLAGS, SUB_KEEP};
    localparam logic [23:0] CTRL = {OBJ_ANALOG_CTRL, SUB_COUNT};
    localparam logic [23:0] AIN1 = {OBJ_ANALOG, SUB_AIN_ONE};

    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;

    dfab_bank i_dut (
        .ref_clk, .rst_n, .busReq, .busRdata, .powerSwitchedOn, .loopDuty, .controlRestart,
        .firmwareDefaultInvert, .autoSetupStart, .motorIsStepper, .adcIn, .pwmDuty,
        .holdTorqueEn, .fieldInverted, .autoSetupNeeded, .autoSetupDone, .gainSet,
        .inputOneCurrentSelect, .inputTwoCurrentSelect
    );

    // ------------------------------------------------------------------
    // Bus and pulse helpers
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic regWrite(input logic [23:0] addr, input logic [31:0] data);
        @(posedge ref_clk);
        busReq.addr <= addr;
        busReq.wdata <= data;
        busReq.wr <= 1'b1;
        @(posedge ref_clk);
        busReq.wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic regCheck(input logic [23:0] addr, input logic [31:0] exp);
        @(posedge ref_clk);
        busReq.addr <= addr;
        busReq.rd <= 1'b1;
        @(posedge ref_clk);
        busReq.rd <= 1'b0;
        #1;
        `CHK(busRdata, exp)
    endtask
    task automatic restart();
        @(posedge ref_clk);
        controlRestart <= 1'b1;
        @(posedge ref_clk);
        controlRestart <= 1'b0;
        tick(3);
    endtask
    task automatic autoSetup();
        @(posedge ref_clk);
        autoSetupStart <= 1'b1;
        @(posedge ref_clk);
        autoSetupStart <= 1'b0;
        #1;
        `CHK(autoSetupDone, 1'b1)
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic checkResetMap();
        regCheck({OBJ_GAINS, SUB_COUNT}, 32'h0000_000a);
        for (int i = 1; i <= 10; i++) begin
            regCheck({OBJ_GAINS, 8'(i)}, presetTab[i-1]);
        end
        regCheck({OBJ_DRIVE_FLAGS, SUB_COUNT}, 32'h0000_0003);
        for (int i = 1; i <= 3; i++) begin
            regCheck({OBJ_DRIVE_FLAGS, 8'(i)}, 32'h0000_0000);
        end
        regCheck({OBJ_ANALOG, SUB_COUNT}, 32'h0000_0002);
        regCheck(CTRL, 32'h0000_0000);
        regWrite(24'h12_3400, 32'hdead_beef);
        regCheck(24'h12_3400, 32'h0000_0000);
    endtask
    // While switched on, half duty unless the loop flag is exactly one
    task automatic checkPower();
        @(posedge ref_clk);
        powerSwitchedOn <= 1'b1;
        tick(2);
        `CHK({pwmDuty, holdTorqueEn}, {16'h8000, 1'b0})
        regWrite(LEGACY, 32'h0000_0001);
        tick(2);
        `CHK({pwmDuty, holdTorqueEn}, {16'h2345, 1'b1})
        regWrite(LEGACY, 32'h0000_00ff);
        regCheck(LEGACY, 32'hffff_ffff);
        `CHK({pwmDuty, holdTorqueEn}, {16'h8000, 1'b0})
        regWrite(LEGACY, 32'h0000_0001);
        @(posedge ref_clk);
        powerSwitchedOn <= 1'b0;
        tick(2);
        `CHK({pwmDuty, holdTorqueEn}, {16'h2345, 1'b0})
    endtask
    // Override takes hold only at a restart
    task automatic checkField();
        `CHK(fieldInverted, 1'b1)
        regWrite(FIELD, 32'h0000_0001);
        tick(3);
        `CHK(fieldInverted, 1'b1)
        restart();
        `CHK({fieldInverted, autoSetupNeeded}, 2'b01)
        regWrite(FIELD, 32'h0000_00ff);
        restart();
        `CHK(fieldInverted, 1'b1)
        regWrite(FIELD, 32'h0000_0000);
        @(posedge ref_clk);
        firmwareDefaultInvert <= 1'b0;
        restart();
        `CHK(fieldInverted, 1'b0)
    endtask
    task automatic checkAutoSetup();
        regWrite({OBJ_GAINS, 8'h01}, 32'h0000_1234);
        regWrite(KEEP, 32'h0000_0001);
        autoSetup();
        tick(1);
        `CHK({autoSetupDone, autoSetupNeeded}, 2'b00)
        `CHK(gainSet[0], 32'h0000_1234)
        regWrite(KEEP, 32'h0000_0000);
        @(posedge ref_clk);
        motorIsStepper <= 1'b0;
        autoSetup();
        regCheck({OBJ_GAINS, 8'h01}, presetTab[0]);
    endtask
    // Readings are read-only and sign-extended; selects follow bits 0 and 1
    task automatic checkAnalog();
        @(posedge ref_clk);
        adcIn <= '{valid: 1'b1, one: 16'h8001, two: 16'h7fff};
        @(posedge ref_clk);
        adcIn.valid <= 1'b0;
        regCheck({OBJ_ANALOG, SUB_AIN_TWO}, 32'h0000_7fff);
        regWrite(AIN1, 32'h0000_0005);
        regCheck(AIN1, 32'hffff_8001);
        regWrite(CTRL, 32'hffff_fffe);
        tick(2);
        `CHK({inputTwoCurrentSelect, inputOneCurrentSelect}, 2'b10)
        regCheck(CTRL, 32'hffff_fffe);
        regWrite(CTRL, 32'h0000_0001);
        tick(2);
        `CHK({inputTwoCurrentSelect, inputOneCurrentSelect}, 2'b01)
    endtask

    task automatic giveVerdict();
        if (errors == 0 && testsRun > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence after twelve reset cycles
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        checkResetMap();
        checkPower();
        checkField();
        checkAutoSetup();
        checkAnalog();
        giveVerdict();
    end
    // Watchdog: the run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        giveVerdict();
    end
endmodule

// ---- sim/dfab_bank_props.sv ----
// Port checker for the drive flags and analog input bank
`timescale 1ns/1ps
module dfab_bank_props (
    input wire logic                  ref_clk,
    input wire logic                  rst_n,
    input wire dfab_pkg::dfab_req_t   busReq,
    input wire logic [31:0]           busRdata,
    input wire logic                  powerSwitchedOn,
    input wire logic [15:0]           loopDuty,
    input wire logic                  controlRestart,
    input wire logic                  firmwareDefaultInvert,
    input wire logic                  autoSetupStart,
    input wire logic                  motorIsStepper,
    input wire dfab_pkg::dfab_adc_t   adcIn,
    input wire logic [15:0]           pwmDuty,
    input wire logic                  holdTorqueEn,
    input wire logic                  fieldInverted,
    input wire logic                  autoSetupNeeded,
    input wire logic                  autoSetupDone,
    input wire dfab_pkg::dfab_gains_t gainSet,
    input wire logic                  inputOneCurrentSelect,
    input wire logic                  inputTwoCurrentSelect
);
    import dfab_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // Shadow copies of the writable flag and control entries and of reading one
    // ------------------------------------------------------------------
    logic [7:0]  legacyQ, fieldQ, keepQ;
    logic [31:0] ctrlQ;
    logic [15:0] ainOneQ;
    wire         ctrlWr = busReq.wr && busReq.addr == {OBJ_ANALOG_CTRL, SUB_COUNT};
    wire         rdLegacy = busReq.rd && busReq.addr == {OBJ_DRIVE_FLAGS, SUB_LEGACY};
    wire         rdAinOne = busReq.rd && busReq.addr == {OBJ_ANALOG, SUB_AIN_ONE};
    wire         rdCtrl = busReq.rd && busReq.addr == {OBJ_ANALOG_CTRL, SUB_COUNT};
    // Field direction that a restart should latch; odd codes fall back to default
    wire         fieldExp = (fieldQ == FLAG_PLUS_ONE) ? 1'b0 :
                            (fieldQ == FLAG_MINUS_ONE) ? 1'b1 : firmwareDefaultInvert;

    // Flag and control shadows follow accepted bus writes only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            legacyQ <= 8'h00;
            fieldQ <= 8'h00;
            keepQ <= 8'h00;
            ctrlQ <= 32'h0000_0000;
        end else if (busReq.wr) begin
            if (busReq.addr == {OBJ_DRIVE_FLAGS, SUB_LEGACY}) legacyQ <= busReq.wdata[7:0];
            if (busReq.addr == {OBJ_DRIVE_FLAGS, SUB_FIELD}) fieldQ <= busReq.wdata[7:0];
            if (busReq.addr == {OBJ_DRIVE_FLAGS, SUB_KEEP}) keepQ <= busReq.wdata[7:0];
            if (ctrlWr) ctrlQ <= busReq.wdata;
        end
    end

    // Converter sample shadow
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) ainOneQ <= 16'h0000;
        else if (adcIn.valid) ainOneQ <= adcIn.one;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_half_duty_hold: assert property (
        powerSwitchedOn && legacyQ != FLAG_PLUS_ONE |=> pwmDuty == PWM_HALF_DUTY && !holdTorqueEn)
        else $error("half duty not held");
    a_loop_torque_drive: assert property (
        powerSwitchedOn && legacyQ == FLAG_PLUS_ONE |=> pwmDuty == $past(loopDuty) && holdTorqueEn)
        else $error("loop duty not driven");
    a_field_after_restart: assert property (
        controlRestart |-> ##2 fieldInverted == $past(fieldExp, 2))
        else $error("field direction wrong after restart");
    a_preset_reload: assert property (
        autoSetupStart && keepQ != FLAG_PLUS_ONE |=> autoSetupDone &&
        gainSet == ($past(motorIsStepper) ? GAIN_PRESET_STEPPER : GAIN_PRESET_BLDC))
        else $error("preset not loaded");
    a_gains_kept: assert property (
        autoSetupStart && keepQ == FLAG_PLUS_ONE && !busReq.wr |=> autoSetupDone && $stable(gainSet))
        else $error("stored gains changed");
    a_reading_readback: assert property (
        rdAinOne && !adcIn.valid |=> busRdata == {{16{ainOneQ[15]}}, ainOneQ})
        else $error("reading not sign extended");
    a_select_follow: assert property (
        ctrlWr ##1 !ctrlWr |=>
        {inputTwoCurrentSelect, inputOneCurrentSelect} == $past(busReq.wdata[1:0], 2))
        else $error("measurement select wrong");
    a_ctrl_readback: assert property (
        rdCtrl |=> busRdata == ctrlQ)
        else $error("control word readback wrong");
    a_flag_signext: assert property (
        rdLegacy |=> busRdata == {{24{legacyQ[7]}}, legacyQ})
        else $error("flag readback wrong");

    // Main scenarios reached
    cover property (autoSetupStart && keepQ == FLAG_PLUS_ONE);
    cover property (controlRestart && fieldQ == FLAG_MINUS_ONE);
    cover property (powerSwitchedOn && legacyQ == FLAG_PLUS_ONE);
endmodule

bind dfab_bank dfab_bank_props i_props (
    .ref_clk, .rst_n, .busReq, .busRdata, .powerSwitchedOn, .loopDuty, .controlRestart,
    .firmwareDefaultInvert, .autoSetupStart, .motorIsStepper, .adcIn, .pwmDuty,
    .holdTorqueEn, .fieldInverted, .autoSetupNeeded, .autoSetupDone, .gainSet,
    .inputOneCurrentSelect, .inputTwoCurrentSelect
);

// ---- verilog/dfab_analog_inputs.sv ----
// Analog input capture and measurement mode selection
`timescale 1ns/1ps
module dfab_analog_inputs (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire dfab_pkg::dfab_adc_t adcIn,
    input  wire logic [31:0]         ctrlWord,
    output logic [15:0]              readingOne,
    output logic [15:0]              readingTwo,
    output logic                     inputOneCurrentSelect,
    output logic                     inputTwoCurrentSelect
);
    import dfab_pkg::*;

    // ------------------------------------------------------------------
    // Readings
    // ------------------------------------------------------------------
    // Hold last converter result; signed digits stored as raw bits
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            readingOne <= READING_RESET;
            readingTwo <= READING_RESET;
        end else if (adcIn.valid) begin
            readingOne <= adcIn.one;
            readingTwo <= adcIn.two;
        end
    end

    // ------------------------------------------------------------------
    // Mode selects
    // ------------------------------------------------------------------
    // Only the two low bits steer the front end; the rest are ignored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            inputOneCurrentSelect <= 1'b0;
            inputTwoCurrentSelect <= 1'b0;
        end else begin
            inputOneCurrentSelect <= ctrlWord[AC_ONE_BIT];
            inputTwoCurrentSelect <= ctrlWord[AC_TWO_BIT];
        end
    end

endmodule

// ---- verilog/dfab_bank.sv ----
// Drive flags, gain and analog input register bank of a motor controller
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module dfab_bank (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire dfab_pkg::dfab_req_t       busReq,
    output logic [dfab_pkg::DATA_W-1:0]    busRdata,
    input  wire logic                      powerSwitchedOn,
    input  wire logic [dfab_pkg::PWM_W-1:0] loopDuty,
    input  wire logic                      controlRestart,
    input  wire logic                      firmwareDefaultInvert,
    input  wire logic                      autoSetupStart,
    input  wire logic                      motorIsStepper,
    input  wire dfab_pkg::dfab_adc_t       adcIn,
    output logic [dfab_pkg::PWM_W-1:0]     pwmDuty,
    output logic                           holdTorqueEn,
    output logic                           fieldInverted,
    output logic                           autoSetupNeeded,
    output logic                           autoSetupDone,
    output dfab_pkg::dfab_gains_t          gainSet,
    output logic                           inputOneCurrentSelect,
    output logic                           inputTwoCurrentSelect
);
    import dfab_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]  legacyPowerSelect_q;
    logic [7:0]  fieldDirectionOverride_q;
    logic [7:0]  keepGainSettings_q;
    logic [31:0] analogModeSelectWord_q;
    logic [1:0]  appliedDir_q;
    logic        autoSetupNeeded_q;
    logic        loadPreset;
    logic        gainWrEn;
    logic [15:0] reqObj;
    logic [7:0]  reqSub;
    logic [15:0] readingOne;
    logic [15:0] readingTwo;
    logic [31:0] rdData_d;

    assign reqObj = busReq.addr[23:8];
    assign reqSub = busReq.addr[7:0];

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Address match used by both the write and the read decoders
    function automatic logic hit(input logic [15:0] obj, input logic [7:0] sub,
                                 input logic [15:0] wantObj, input logic [7:0] wantSub);
        hit = (obj == wantObj) && (sub == wantSub);
    endfunction

    // Flag value checks; anything outside the documented set acts as zero
    function automatic logic isPlusOne(input logic [7:0] flag);
        isPlusOne = (flag == FLAG_PLUS_ONE);
    endfunction

    // Gain entry numbers run 1..10; table index is one less
    function automatic logic gainHit(input logic [15:0] obj, input logic [7:0] sub);
        gainHit = (obj == OBJ_GAINS) && (sub != SUB_COUNT) && (sub <= SUB_GAIN_MAX);
    endfunction

    // ------------------------------------------------------------------
    // Drive flag registers
    // ------------------------------------------------------------------
    // Full signed byte is stored so software reads back what it wrote
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            legacyPowerSelect_q      <= FLAG_RESET;
            fieldDirectionOverride_q <= FLAG_RESET;
            keepGainSettings_q       <= FLAG_RESET;
        end else if (busReq.wr) begin
            if (hit(reqObj, reqSub, OBJ_DRIVE_FLAGS, SUB_LEGACY)) begin
                legacyPowerSelect_q <= busReq.wdata[7:0];
            end else if (hit(reqObj, reqSub, OBJ_DRIVE_FLAGS, SUB_FIELD)) begin
                fieldDirectionOverride_q <= busReq.wdata[7:0];
            end else if (hit(reqObj, reqSub, OBJ_DRIVE_FLAGS, SUB_KEEP)) begin
                keepGainSettings_q <= busReq.wdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Analog control word
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            analogModeSelectWord_q <= ANALOG_CTRL_RST;
        end else if (busReq.wr && hit(reqObj, reqSub, OBJ_ANALOG_CTRL, SUB_COUNT)) begin
            analogModeSelectWord_q <= busReq.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Rotating field direction
    // ------------------------------------------------------------------
    // Direction code: 00 firmware default, 01 forced positive, 10 forced
    // negative. Sampled only on restart so a live edit cannot flip the
    // field under a running motor.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            appliedDir_q <= 2'h0;
        end else if (controlRestart) begin
            if (fieldDirectionOverride_q == FLAG_PLUS_ONE) begin
                appliedDir_q <= 2'h1;
            end else if (fieldDirectionOverride_q == FLAG_MINUS_ONE) begin
                appliedDir_q <= 2'h2;
            end else begin
                appliedDir_q <= 2'h0;
            end
        end
    end

    // Field polarity to the commutation logic
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fieldInverted <= 1'b0;
        end else begin
            case (appliedDir_q)
                2'h1:    fieldInverted <= 1'b0;
                2'h2:    fieldInverted <= 1'b1;
                default: fieldInverted <= firmwareDefaultInvert;
            endcase
        end
    end

    // Restart asks software for a fresh auto setup; a restart in the
    // same cycle as the auto setup start wins over the clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            autoSetupNeeded_q <= 1'b0;
        end else if (controlRestart) begin
            autoSetupNeeded_q <= 1'b1;
        end else if (autoSetupStart) begin
            autoSetupNeeded_q <= 1'b0;
        end
    end
    assign autoSetupNeeded = autoSetupNeeded_q;

    // ------------------------------------------------------------------
    // Auto setup gain handling
    // ------------------------------------------------------------------
    // Only keep flag exactly one protects the stored gains
    assign loadPreset = autoSetupStart && !isPlusOne(keepGainSettings_q);

    // Done strobe one cycle after start, with or without a reload
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            autoSetupDone <= 1'b0;
        end else begin
            autoSetupDone <= autoSetupStart;
        end
    end

    assign gainWrEn = busReq.wr && gainHit(reqObj, reqSub);

    dfab_gain_store u_gains (
        .ref_clk        (ref_clk),
        .rst_n          (rst_n),
        .wrEn           (gainWrEn),
        .wrIdx          (4'(reqSub - 8'h01)),
        .wrData         (busReq.wdata),
        .loadPreset     (loadPreset),
        .motorIsStepper (motorIsStepper),
        .gainSet        (gainSet)
    );

    // ------------------------------------------------------------------
    // PWM output selection
    // ------------------------------------------------------------------
    // Outside switched on the power stage is handled elsewhere; the loop
    // duty is passed through and holding torque is held off
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwmDuty      <= PWM_HALF_DUTY;
            holdTorqueEn <= 1'b0;
        end else if (powerSwitchedOn && !isPlusOne(legacyPowerSelect_q)) begin
            pwmDuty      <= PWM_HALF_DUTY;
            holdTorqueEn <= 1'b0;
        end else if (powerSwitchedOn) begin
            pwmDuty      <= loopDuty;
            holdTorqueEn <= 1'b1;
        end else begin
            pwmDuty      <= loopDuty;
            holdTorqueEn <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Analog inputs
    // ------------------------------------------------------------------
    // Readings are raw digits; scaling to mA is left to software
    dfab_analog_inputs u_analog (
        .ref_clk               (ref_clk),
        .rst_n                 (rst_n),
        .adcIn                 (adcIn),
        .ctrlWord              (analogModeSelectWord_q),
        .readingOne            (readingOne),
        .readingTwo            (readingTwo),
        .inputOneCurrentSelect (inputOneCurrentSelect),
        .inputTwoCurrentSelect (inputTwoCurrentSelect)
    );

    // ------------------------------------------------------------------
    // Read decoder
    // ------------------------------------------------------------------
    // Signed byte and halfword entries are sign extended to 32 bits;
    // unmapped addresses read zero
    always_comb begin
        rdData_d = 32'h0000_0000;
        if (hit(reqObj, reqSub, OBJ_GAINS, SUB_COUNT)) begin
            rdData_d = {24'h00_0000, GAIN_ENTRY_COUNT};
        end else if (gainHit(reqObj, reqSub)) begin
            rdData_d = gainSet[4'(reqSub - 8'h01)];
        end else if (hit(reqObj, reqSub, OBJ_DRIVE_FLAGS, SUB_COUNT)) begin
            rdData_d = {24'h00_0000, DRIVE_ENTRY_COUNT};
        end else if (hit(reqObj, reqSub, OBJ_DRIVE_FLAGS, SUB_LEGACY)) begin
            rdData_d = {{24{legacyPowerSelect_q[7]}}, legacyPowerSelect_q};
        end else if (hit(reqObj, reqSub, OBJ_DRIVE_FLAGS, SUB_FIELD)) begin
            rdData_d = {{24{fieldDirectionOverride_q[7]}}, fieldDirectionOverride_q};
        end else if (hit(reqObj, reqSub, OBJ_DRIVE_FLAGS, SUB_KEEP)) begin
            rdData_d = {{24{keepGainSettings_q[7]}}, keepGainSettings_q};
        end else if (hit(reqObj, reqSub, OBJ_ANALOG, SUB_COUNT)) begin
            rdData_d = {24'h00_0000, ANALOG_ENTRY_COUNT};
        end else if (hit(reqObj, reqSub, OBJ_ANALOG, SUB_AIN_ONE)) begin
            rdData_d = {{16{readingOne[15]}}, readingOne};
        end else if (hit(reqObj, reqSub, OBJ_ANALOG, SUB_AIN_TWO)) begin
            rdData_d = {{16{readingTwo[15]}}, readingTwo};
        end else if (hit(reqObj, reqSub, OBJ_ANALOG_CTRL, SUB_COUNT)) begin
            rdData_d = analogModeSelectWord_q;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busRdata <= 32'h0000_0000;
        end else if (busReq.rd) begin
            busRdata <= rdData_d;
        end else begin
            busRdata <= 32'h0000_0000;
        end
    end

endmodule

// ---- verilog/dfab_gain_store.sv ----
// Controller gain table with preset loading for auto setup
`timescale 1ns/1ps
module dfab_gain_store (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 wrEn,
    input  wire logic [3:0]           wrIdx,
    input  wire logic [31:0]          wrData,
    input  wire logic                 loadPreset,
    input  wire logic                 motorIsStepper,
    output dfab_pkg::dfab_gains_t     gainSet
);
    import dfab_pkg::*;

    // ------------------------------------------------------------------
    // Table update
    // ------------------------------------------------------------------
    // Preset load wins over a same-cycle software write: auto setup owns
    // the table while it reloads it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gainSet <= GAIN_PRESET_STEPPER;
        end else if (loadPreset) begin
            gainSet <= motorIsStepper ? GAIN_PRESET_STEPPER : GAIN_PRESET_BLDC;
        end else if (wrEn && wrIdx < 4'(GAIN_COUNT)) begin
            gainSet[wrIdx] <= wrData;
        end
    end

endmodule

// ---- verilog/dfab_pkg.sv ----
// Constants and carrier types for the drive flags and analog input bank
package dfab_pkg;

    // ------------------------------------------------------------------
    // Register addressing: {object index, entry number}
    // ------------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam logic [15:0] OBJ_GAINS       = 16'h3210;
    localparam logic [15:0] OBJ_DRIVE_FLAGS = 16'h3212;
    localparam logic [15:0] OBJ_ANALOG      = 16'h3220;
    localparam logic [15:0] OBJ_ANALOG_CTRL = 16'h3221;

    // Entry numbers inside the objects
    localparam logic [7:0] SUB_COUNT    = 8'h00;
    localparam logic [7:0] SUB_LEGACY   = 8'h01;
    localparam logic [7:0] SUB_FIELD    = 8'h02;
    localparam logic [7:0] SUB_KEEP     = 8'h03;
    localparam logic [7:0] SUB_AIN_ONE  = 8'h01;
    localparam logic [7:0] SUB_AIN_TWO  = 8'h02;
    localparam logic [7:0] SUB_GAIN_MAX = 8'h0a;

    // Read-only entry counts
    localparam logic [7:0] GAIN_ENTRY_COUNT   = 8'h0a;
    localparam logic [7:0] DRIVE_ENTRY_COUNT  = 8'h03;
    localparam logic [7:0] ANALOG_ENTRY_COUNT = 8'h02;

    // Reset values
    localparam logic [7:0]  FLAG_RESET      = 8'h00;
    localparam logic [31:0] ANALOG_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] READING_RESET   = 16'h0000;

    // Field positions in the analog control word
    localparam int AC_ONE_BIT = 0;
    localparam int AC_TWO_BIT = 1;

    // Drive flag encodings (signed 8 bit)
    localparam logic [7:0] FLAG_ZERO      = 8'h00;
    localparam logic [7:0] FLAG_PLUS_ONE  = 8'h01;
    localparam logic [7:0] FLAG_MINUS_ONE = 8'hff;

    // PWM duty
    localparam int PWM_W = 16;
    localparam logic [PWM_W-1:0] PWM_HALF_DUTY = 16'h8000;

    // Gain table
    localparam int GAIN_COUNT = 10;
    typedef logic [GAIN_COUNT-1:0][DATA_W-1:0] dfab_gains_t;

    // Stepper preset set, entry 1 in the low word
    localparam dfab_gains_t GAIN_PRESET_STEPPER = {
        32'h0000_afc8, 32'h0003_a980, 32'h0000_2ee0, 32'h0006_68a0,
        32'h0000_2ee0, 32'h0006_68a0, 32'h0000_001e, 32'h0000_2ee0,
        32'h0000_0000, 32'h0000_0800};
    // BLDC preset set
    localparam dfab_gains_t GAIN_PRESET_BLDC = {
        32'h0000_afc8, 32'h0003_a980, 32'h0000_2ee0, 32'h0006_68a0,
        32'h0000_2ee0, 32'h0006_68a0, 32'h0000_001e, 32'h0000_2ee0,
        32'h0000_0000, 32'h0000_0800};

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } dfab_req_t;

    // Converter samples
    typedef struct packed {
        logic        valid;
        logic [15:0] one;
        logic [15:0] two;
    } dfab_adc_t;

endpackage
